// ==== rtl/sensor_correction_math_pdm_regs.svh ====
// constants of the sensor correction datapath: offsets, fields, resets, limits
// assumes a plain one-cycle register port and a 50 MHz system clock
//
// What this block does
// - config bit 15 picks parabolic or S-shaped
// - coefficients are 24-bit sign-magnitude words
// - coefficients load into 26-bit calculation registers
// - magnitude shifted left two, msb aligned
// - K1 gain factor from temperature terms
// - K2 offset term from cap and temperature
// - parabolic intermediate, bounded positive
// - parabolic sensor output, bounded positive
// - S-shaped intermediate, product and result saturate
// - S-shaped output uses absolute intermediate
// - corrected sensor value clamped 0 to FFFFF
// - saturate at limit and flag it
// - temperature correction always parabolic
// - temperature intermediate bounded positive
// - corrected temperature from intermediate, bounded positive
// - corrected temperature clamped 0 to FFFFFF
// - density output needs cyclic measurement mode
// - no sleep while density output runs
// - density output starts itself after reset
// - modulator fed only by compensated sensor value
// - modulator input scaled to 16 bits
// - status bit 0 shows last measurement saturation
`ifndef SENSOR_CORRECTION_MATH_PDM_REGS_SVH
`define SENSOR_CORRECTION_MATH_PDM_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define OFS_CONFIG 8'h00
`define OFS_COMMAND 8'h04
`define OFS_STATUS 8'h08
`define OFS_SENSOR_RESULT 8'h0c
`define OFS_TEMP_RESULT 8'h10
`define OFS_COEF_BASE 8'h40
`define NUM_COEFS 12

// ----------------------------------------
// fields
// ----------------------------------------
`define CFG_CURVE_BIT 15
`define CFG_DENSITY_BIT 9
`define CFG_CYCLIC_BIT 10
`define STAT_SAT_BIT 0
`define STAT_BUSY_BIT 5
`define CMD_MEASURE_BIT 0
`define COEF_SIGN_BIT 23

// ----------------------------------------
// reset values and math limits
// ----------------------------------------
`define CONFIG_RESET 16'h0000
`define TWO_POW_23 42'sh0_0080_0000
`define POS_LIMIT 42'sh0_01ff_ffff
`define NEG_LIMIT -42'sh0_0200_0000
`define SENSOR_MAX 42'sh0_000f_ffff
`define TEMP_MAX 42'sh0_00ff_ffff
`define FRAC_SHIFT 23

`endif

// ==== rtl/sensor_correction_math_pdm_pkg.sv ====
// types of the sensor correction datapath
// assumes the constants header is included by the design file
package sensor_correction_math_pdm_pkg;

  // wide signed intermediate, headroom above the 26-bit datapath
  typedef logic signed [41:0] wide_type;
  typedef logic signed [25:0] calc_type;

  // raw readings from the front end, auto-zeroed, two's complement
  typedef struct packed {
    logic signed [23:0] cap;
    logic signed [23:0] temp;
  } raw_sample_type;

  // corrected results towards the readout
  typedef struct packed {
    logic [19:0] sensor;
    logic [23:0] temp;
  } result_type;

  // coefficient slots
  typedef enum logic [3:0] {
    CO_GAIN_S = 4'h0, CO_OFFSET_S = 4'h1, CO_TCG = 4'h2, CO_TCO = 4'h3,
    CO_GAIN_TC_QUADRATIC = 4'h4, CO_OFFSET_TC_QUADRATIC = 4'h5, CO_SENSOR_QUADRATIC_COEFF = 4'h6, CO_SENSOR_SHIFT = 4'h7,
    CO_GAIN_T = 4'h8, CO_OFFSET_T = 4'h9, CO_TEMP_QUADRATIC_COEFF = 4'ha, CO_T_SHIFT = 4'hb
  } coef_type;

  // sequencer, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_LOAD = 10'h002, ST_ZT = 10'h004, ST_T = 10'h008,
    ST_K1 = 10'h010, ST_K2 = 10'h020, ST_P = 10'h040, ST_Z = 10'h080,
    ST_S = 10'h100, ST_DONE = 10'h200
  } state_type;

endpackage

// ==== rtl/sensor_correction_math_pdm.sv ====
// sensor and temperature correction datapath with a density-modulated output
// assumes raw readings arrive as a one-cycle strobe, synchronous to clk_sys_i
`timescale 1ns/100ps
`include "sensor_correction_math_pdm_regs.svh"

module sensor_correction_math_pdm (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic [15:0] nvm_config_i,
  input wire logic raw_valid_i,
  input wire sensor_correction_math_pdm_pkg::raw_sample_type raw_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output sensor_correction_math_pdm_pkg::result_type result_o,
  output logic result_valid_o,
  output logic busy_o,
  output logic math_sat_o,
  output logic pdm_o,
  output logic sleep_allow_o
);
  import sensor_correction_math_pdm_pkg::*;

  // ----------------------------------------
  // arithmetic helpers
  // ----------------------------------------
  // multiply and drop the 23 fraction bits
  function automatic wide_type mul23(input wide_type a, input wide_type b);
    logic signed [83:0] p;
    p = a * b;
    return p[64:23];
  endfunction

  function automatic wide_type clamp(input wide_type x, input wide_type lo, input wide_type hi);
    if (x < lo) begin
      return lo;
    end else if (x > hi) begin
      return hi;
    end
    return x;
  endfunction

  function automatic wide_type widen(input calc_type c);
    return {{16{c[25]}}, c};
  endfunction

  // sign-magnitude to 26-bit two's complement, magnitude moved up two places
  function automatic calc_type load_coef(input logic [23:0] w);
    calc_type m;
    m = {1'b0, w[22:0], 2'b00};
    return w[`COEF_SIGN_BIT] ? -m : m;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  state_type state_q;
  logic [15:0] cfg_q;
  logic cfg_loaded_q;
  logic [23:0] coef_word_q [`NUM_COEFS];
  calc_type coef_q [`NUM_COEFS];
  raw_sample_type raw_q;
  calc_type zt_q, k1_q, k2_q, p_q, z_q;
  logic [23:0] t_q;
  logic [19:0] s_q;
  logic sat_acc_q;
  logic status_sat_q;
  logic [16:0] sd_acc_q;
  wide_type stage_w, stage_lo, stage_hi, stage_out, inner, traw, sraw, zw;
  logic stage_flag;
  logic take;
  logic curve_s;
  logic density_active;
  logic cmd_plain;
  logic coef_hit;
  logic [3:0] coef_idx;

  assign take = raw_valid_i && (state_q == ST_IDLE);
  assign curve_s = cfg_q[`CFG_CURVE_BIT];
  assign density_active = cfg_q[`CFG_DENSITY_BIT] && cfg_q[`CFG_CYCLIC_BIT];
  assign cmd_plain = wr_i && (addr_i == `OFS_COMMAND) && !wdata_i[`CMD_MEASURE_BIT];
  assign coef_hit = (addr_i >= `OFS_COEF_BASE) && (addr_i < 8'(`OFS_COEF_BASE + 4 * `NUM_COEFS))
                    && (addr_i[1:0] == 2'b00);
  assign coef_idx = 4'((addr_i - `OFS_COEF_BASE) >> 2);
  assign traw = {{18{raw_q.temp[23]}}, raw_q.temp};
  assign sraw = {{18{raw_q.cap[23]}}, raw_q.cap};
  assign zw = widen(z_q);

  // ----------------------------------------
  // configuration and coefficient store
  // ----------------------------------------
  // the config word is taken from memory one edge after reset, so density
  // output needs no software action to start
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cfg_q <= `CONFIG_RESET;
      cfg_loaded_q <= 1'b0;
    end else if (!cfg_loaded_q) begin
      cfg_q <= nvm_config_i;
      cfg_loaded_q <= 1'b1;
    end else if (wr_i && addr_i == `OFS_CONFIG) begin
      cfg_q <= wdata_i[15:0];
    end
  end

  // raw words are kept as written; a write lands in the next measurement
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_COEFS; gi++) begin : g_coef
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          coef_word_q[gi] <= 24'h00_0000;
        end else if (wr_i && coef_hit && coef_idx == 4'(gi)) begin
          coef_word_q[gi] <= wdata_i[23:0];
        end
      end
      // loading once per measurement keeps the words stable during the math
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          coef_q[gi] <= 26'sh000_0000;
        end else if (state_q == ST_LOAD) begin
          coef_q[gi] <= load_coef(coef_word_q[gi]);
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // temperature terms go first: K1 and K2 both lean on the same raw temperature
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: state_q <= take ? ST_LOAD : ST_IDLE;
        ST_LOAD: state_q <= ST_ZT;
        ST_ZT: state_q <= ST_T;
        ST_T: state_q <= ST_K1;
        ST_K1: state_q <= ST_K2;
        ST_K2: state_q <= ST_P;
        ST_P: state_q <= ST_Z;
        ST_Z: state_q <= ST_S;
        ST_S: state_q <= ST_DONE;
        ST_DONE: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      raw_q <= '0;
    end else if (take) begin
      raw_q <= raw_i;
    end
  end

  // ----------------------------------------
  // one equation step per state, then a bound
  // ----------------------------------------
  always_comb begin
    stage_w = '0;
    inner = '0;
    stage_lo = `NEG_LIMIT;
    stage_hi = `POS_LIMIT;
    unique case (state_q)
      ST_ZT: begin
        stage_w = mul23(widen(coef_q[CO_GAIN_T]), traw + widen(coef_q[CO_OFFSET_T])) + `TWO_POW_23;
        stage_lo = '0;
      end
      ST_T: begin
        inner = mul23(widen(coef_q[CO_TEMP_QUADRATIC_COEFF]), widen(zt_q)) + `TWO_POW_23;
        stage_w = mul23(widen(zt_q), inner) + widen(coef_q[CO_T_SHIFT]);
        stage_lo = '0;
        stage_hi = `TEMP_MAX;
      end
      ST_K1: begin
        inner = mul23(widen(coef_q[CO_GAIN_TC_QUADRATIC]), traw) + widen(coef_q[CO_TCG]);
        stage_w = `TWO_POW_23 + mul23(traw, inner);
      end
      ST_K2: begin
        inner = mul23(widen(coef_q[CO_OFFSET_TC_QUADRATIC]), traw) + widen(coef_q[CO_TCO]);
        stage_w = widen(coef_q[CO_OFFSET_S]) + sraw + mul23(traw, inner);
      end
      ST_P: begin
        stage_w = mul23(widen(k1_q), widen(k2_q));
      end
      ST_Z: begin
        if (curve_s) begin
          stage_w = mul23(widen(coef_q[CO_GAIN_S]), widen(p_q));
        end else begin
          stage_w = mul23(widen(coef_q[CO_GAIN_S]), widen(p_q)) + `TWO_POW_23;
          stage_lo = '0;
        end
      end
      ST_S: begin
        if (curve_s) begin
          inner = mul23(widen(coef_q[CO_SENSOR_QUADRATIC_COEFF]), (zw < 0) ? -zw : zw) + `TWO_POW_23;
          stage_w = mul23(zw, inner) + `TWO_POW_23 + widen(coef_q[CO_SENSOR_SHIFT]);
        end else begin
          inner = mul23(widen(coef_q[CO_SENSOR_QUADRATIC_COEFF]), zw) + `TWO_POW_23;
          stage_w = mul23(zw, inner) + widen(coef_q[CO_SENSOR_SHIFT]);
        end
        stage_lo = '0;
        stage_hi = `SENSOR_MAX;
      end
      default: begin
        stage_w = '0;
      end
    endcase
    stage_out = clamp(stage_w, stage_lo, stage_hi);
    stage_flag = (stage_w < stage_lo) || (stage_w > stage_hi);
  end

  // step results, each written in its own state only
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      zt_q <= '0;
      t_q <= '0;
      k1_q <= '0;
      k2_q <= '0;
      p_q <= '0;
      z_q <= '0;
      s_q <= '0;
    end else begin
      if (state_q == ST_ZT) zt_q <= stage_out[25:0];
      if (state_q == ST_T) t_q <= stage_out[23:0];
      if (state_q == ST_K1) k1_q <= stage_out[25:0];
      if (state_q == ST_K2) k2_q <= stage_out[25:0];
      if (state_q == ST_P) p_q <= stage_out[25:0];
      if (state_q == ST_Z) z_q <= stage_out[25:0];
      if (state_q == ST_S) s_q <= stage_out[19:0];
    end
  end

  // any bound hit during a run is remembered until the run ends
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || state_q == ST_LOAD) begin
      sat_acc_q <= 1'b0;
    end else if (stage_flag) begin
      sat_acc_q <= 1'b1;
    end
  end

  // end of run wins over a plain command in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      status_sat_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      status_sat_q <= sat_acc_q;
    end else if (cmd_plain) begin
      status_sat_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // results and status outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      result_o <= '0;
      result_valid_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      result_valid_o <= (state_q == ST_DONE);
      if (state_q == ST_DONE) begin
        result_o.sensor <= s_q;
        result_o.temp <= t_q;
      end
      if (take) begin
        busy_o <= 1'b1;
      end else if (state_q == ST_DONE) begin
        busy_o <= 1'b0;
      end
    end
  end
  assign math_sat_o = status_sat_q;

  // ----------------------------------------
  // density modulator
  // ----------------------------------------
  // first order: the carry of a 16-bit accumulator is the pulse stream;
  // the corrected sensor value is the only source
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sd_acc_q <= '0;
      pdm_o <= 1'b0;
      sleep_allow_o <= 1'b1;
    end else begin
      sleep_allow_o <= !density_active;
      if (density_active) begin
        sd_acc_q <= {1'b0, sd_acc_q[15:0]} + {1'b0, result_o.sensor[19:4]};
        pdm_o <= sd_acc_q[16];
      end else begin
        sd_acc_q <= '0;
        pdm_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // register read port, data one cycle after the strobe
  // ----------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= '0;
      if (addr_i == `OFS_CONFIG) begin
        rdata_o <= {16'h0000, cfg_q};
      end else if (addr_i == `OFS_STATUS) begin
        rdata_o[`STAT_SAT_BIT] <= status_sat_q;
        rdata_o[`STAT_BUSY_BIT] <= busy_o;
      end else if (addr_i == `OFS_SENSOR_RESULT) begin
        rdata_o <= {12'h000, result_o.sensor};
      end else if (addr_i == `OFS_TEMP_RESULT) begin
        rdata_o <= {8'h00, result_o.temp};
      end else if (coef_hit) begin
        rdata_o <= {8'h00, coef_word_q[coef_idx]};
      end
    end else begin
      rdata_o <= '0;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);

  sequence s_taken;
    raw_valid_i && state_q == ST_IDLE;
  endsequence
  // the done state costs one more busy cycle before the result pulse
  sequence s_run;
    busy_o [*8] ##1 (busy_o && state_q == ST_DONE) ##1 (result_valid_o && !busy_o);
  endsequence

  a_run_latency: assert property (s_taken |=> s_run)
    else $error("result not delivered ten cycles after a raw sample");
  a_temp_first: assert property (state_q == ST_K1 |-> $past(state_q) == ST_T)
    else $error("sensor terms started before temperature terms");
  a_coef_align: assert property (state_q == ST_LOAD && !coef_word_q[0][23]
    |=> coef_q[0] == {1'b0, $past(coef_word_q[0][22:0]), 2'b00})
    else $error("coefficient not aligned to the register msb");
  // both outputs are bounded before they are cut to their field widths
  a_sensor_bound: assert property (state_q == ST_S |-> stage_out >= 0 && stage_out <= `SENSOR_MAX)
    else $error("sensor result outside its range");
  a_temp_bound: assert property (state_q == ST_T |-> stage_out >= 0 && stage_out <= `TEMP_MAX)
    else $error("temperature result outside its range");
  a_sat_report: assert property (state_q == ST_DONE |=> status_sat_q == $past(sat_acc_q))
    else $error("saturation not reported after a measurement");
  a_sat_clear: assert property (cmd_plain && state_q != ST_DONE |=> !status_sat_q)
    else $error("status saturation survived a plain command");
  a_no_sleep: assert property (density_active |=> !sleep_allow_o)
    else $error("sleep allowed while density output runs");
  a_pdm_quiet: assert property (!density_active |=> !pdm_o)
    else $error("density output active outside cyclic mode");
  a_flag_bound: assert property (stage_flag |=> sat_acc_q)
    else $error("bound hit not remembered");
  // with a positive factor the magnitude keeps the quadratic term at one or more
  a_abs_term: assert property (state_q == ST_S && curve_s && coef_q[CO_SENSOR_QUADRATIC_COEFF] >= 0
    |-> inner >= `TWO_POW_23)
    else $error("s-shaped quadratic term not built from the magnitude");
  a_cfg_load: assert property (!cfg_loaded_q |=> cfg_q == $past(nvm_config_i))
    else $error("config word not taken from memory after reset");

endmodule

// ==== tb/adc_nvm_model.sv ====
// model of the front end and the configuration memory that feed the datapath
// assumes the bench calls set_image() and present() from its own sequence
`timescale 1ns/100ps

module adc_nvm_model (
  input wire logic clk_sys_i,
  output logic [15:0] nvm_config_o,
  output logic raw_valid_o,
  output sensor_correction_math_pdm_pkg::raw_sample_type raw_o
);
  import sensor_correction_math_pdm_pkg::*;

  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    nvm_config_o = 16'h0000;
    raw_valid_o = 1'b0;
    raw_o = '0;
  end

  // ----------------------------------------
  // stimulus tasks
  // ----------------------------------------
  // config image; the device only reads it after a reset release
  task automatic set_image(input logic [15:0] w);
    nvm_config_o <= w;
  endtask

  // one sample strobe; cap and temp always come from the same cycle
  task automatic present(input logic [23:0] cap, input logic [23:0] temp);
    @(posedge clk_sys_i);
    raw_valid_o <= 1'b1;
    raw_o <= {cap, temp};
    @(posedge clk_sys_i);
    raw_valid_o <= 1'b0;
    // a released bus must not keep showing the old sample
    raw_o <= ~{cap, temp};
  endtask
endmodule

// ==== tb/sensor_correction_math_pdm_tb.sv ====
// self-checking bench of the correction datapath and its density output
// assumes the register port of the design and the front-end model beside it
`timescale 1ns/100ps
`include "sensor_correction_math_pdm_regs.svh"

module sensor_correction_math_pdm_tb;
  import sensor_correction_math_pdm_pkg::*;

  logic clk_sys_i;
  logic srst_i;
  logic [15:0] nvm_config_i;
  logic raw_valid_i;
  raw_sample_type raw_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  result_type result_o;
  logic result_valid_o;
  logic busy_o;
  logic math_sat_o;
  logic pdm_o;
  logic sleep_allow_o;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  sensor_correction_math_pdm dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .nvm_config_i(nvm_config_i),
    .raw_valid_i(raw_valid_i), .raw_i(raw_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .result_o(result_o),
    .result_valid_o(result_valid_o), .busy_o(busy_o), .math_sat_o(math_sat_o),
    .pdm_o(pdm_o), .sleep_allow_o(sleep_allow_o)
  );

  adc_nvm_model adc_u (
    .clk_sys_i(clk_sys_i), .nvm_config_o(nvm_config_i), .raw_valid_o(raw_valid_i), .raw_o(raw_i)
  );

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // the density window dominates the run; 20000 cycles leaves ample margin
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask

  task automatic setc(input coef_type c, input logic [23:0] v);
    wr(`OFS_COEF_BASE + {2'b00, c, 2'b00}, {8'h00, v});
  endtask

  task automatic do_reset(input logic [15:0] image);
    adc_u.set_image(image);
    @(posedge clk_sys_i);
    srst_i <= 1'b1;
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // one run; a second sample while busy must leave the results alone
  task automatic measure(input logic [23:0] cap, input logic [23:0] temp, input logic intrude,
                         input logic [19:0] exp_s, input logic [23:0] exp_t, input logic exp_sat);
    int n;
    adc_u.present(cap, temp);
    #1;
    chk({31'h0, busy_o}, 32'h1);
    n = 0;
    if (intrude) begin
      adc_u.present(24'h7fffff, 24'h123456);
      n = 2;
    end
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (result_valid_o !== 1'b1 && n < 20);
    chk(32'(n), 32'd9); // result pulse nine edges after the take edge
    chk({31'h0, busy_o}, 32'h0);
    chk({12'h0, result_o.sensor}, {12'h0, exp_s});
    chk({8'h0, result_o.temp}, {8'h0, exp_t});
    chk({31'h0, math_sat_o}, {31'h0, exp_sat});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic scen_reset();
    #1;
    chk({27'h0, result_valid_o, busy_o, math_sat_o, pdm_o, sleep_allow_o}, 32'h1);
    chk({12'h0, result_o.sensor}, 32'h0);
    rd(`OFS_CONFIG, 32'h0);
  endtask

  task automatic scen_regs();
    setc(CO_SENSOR_SHIFT, 24'h9c4000);
    rd(`OFS_COEF_BASE + 8'h1c, 32'h009c4000);
    wr(8'hfc, 32'hffffffff);
    rd(8'hfc, 32'h0);
    rd(`OFS_STATUS, 32'h0);
  endtask

  // gains of one, negative shift: sign and x4 load both matter
  task automatic scen_parabolic();
    setc(CO_GAIN_S, 24'h200000);
    setc(CO_TCG, 24'h200000);
    setc(CO_GAIN_T, 24'h200000);
    measure(24'h000100, 24'h400000, 1'b1, 20'hf0180, 24'hc00000, 1'b0);
    rd(`OFS_SENSOR_RESULT, 32'h000f0180);
    rd(`OFS_TEMP_RESULT, 32'h00c00000);
  endtask

  task automatic scen_density();
    int ones;
    wr(`OFS_CONFIG, 32'h00000200);
    repeat (2) @(posedge clk_sys_i);
    ones = 0;
    repeat (64) begin
      @(posedge clk_sys_i);
      #1;
      ones += (pdm_o === 1'b1);
    end
    chk({31'h0, sleep_allow_o}, 32'h1);
    chk(32'(ones), 32'h0);
    wr(`OFS_CONFIG, 32'h00000600);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({31'h0, sleep_allow_o}, 32'h0);
    ones = 0;
    // sensor bits 19:4 are 0xf018, so 4096 cycles give 3841.5 ones
    repeat (4096) begin
      @(posedge clk_sys_i);
      #1;
      ones += (pdm_o === 1'b1);
    end
    chk({31'h0, ones >= 3840 && ones <= 3843}, 32'h1);
    wr(`OFS_CONFIG, 32'h0);
  endtask

  // same inputs through both curves; only the absolute value keeps s-shaped in range
  task automatic scen_curves();
    setc(CO_TCG, 24'h000000);
    setc(CO_SENSOR_QUADRATIC_COEFF, 24'h200000);
    setc(CO_SENSOR_SHIFT, 24'h844000);
    measure(24'hc00000, 24'h000000, 1'b0, 20'hfffff, 24'h800000, 1'b1);
    wr(`OFS_COMMAND, 32'h0);
    rd(`OFS_STATUS, 32'h0);
    wr(`OFS_CONFIG, 32'h00008000);
    measure(24'hc00000, 24'h000000, 1'b0, 20'hf0000, 24'h800000, 1'b0);
    wr(`OFS_CONFIG, 32'h0);
    measure(24'h800000, 24'h000000, 1'b0, 20'h00000, 24'h800000, 1'b1);
    rd(`OFS_STATUS, 32'h1);
    wr(`OFS_COMMAND, 32'h1);
    rd(`OFS_STATUS, 32'h1);
  endtask

  // every temperature term in use: K1=0x940000, K2=0x40000, Z=0x84a000, T=0x400000
  task automatic scen_terms();
    setc(CO_OFFSET_T, 24'h080000);
    setc(CO_TEMP_QUADRATIC_COEFF, 24'h900000);
    setc(CO_T_SHIFT, 24'h040000);
    setc(CO_GAIN_TC_QUADRATIC, 24'h100000);
    setc(CO_TCG, 24'h100000);
    setc(CO_OFFSET_TC_QUADRATIC, 24'h100000);
    setc(CO_TCO, 24'h900000);
    setc(CO_OFFSET_S, 24'h040000);
    setc(CO_SENSOR_QUADRATIC_COEFF, 24'h000000);
    setc(CO_SENSOR_SHIFT, 24'h9e8000);
    measure(24'h000000, 24'h200000, 1'b0, 20'haa000, 24'h400000, 1'b0);
  endtask

  task automatic scen_power_on();
    do_reset(16'h0600);
    #1;
    chk({31'h0, sleep_allow_o}, 32'h0);
    rd(`OFS_CONFIG, 32'h00000600);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    srst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    // the recommended parabolic curve is the power-on choice
    do_reset(16'h0000);
    scen_reset();
    scen_regs();
    scen_parabolic();
    scen_density();
    scen_curves();
    scen_terms();
    scen_power_on();
    close_out();
  end
endmodule
